// ===== verilog/stc_map.vh
`ifndef STC_MAP_VH
`define STC_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define STC_OFS_CTRL1     12'h000
`define STC_OFS_CTRL2     12'h004
`define STC_OFS_CTRL5     12'h008
`define STC_OFS_CTRL6     12'h00C
`define STC_OFS_EVENT_CONTROL_REGISTER    12'h010
`define STC_OFS_FLAGS     12'h014
`define STC_OFS_TALLY     12'h020
`define STC_OFS_CYCLE     12'h024
`define STC_OFS_CYCLE_STG 12'h028
`define STC_OFS_MATCH0    12'h030
`define STC_OFS_STG0      12'h040

// ----------------------------------------
// field positions
// ----------------------------------------
`define STC_CTRL1_ENABLE  0
`define STC_CTRL1_PSC_LSB 1
`define STC_CTRL1_PSC_MSB 3
`define STC_CTRL2_WAVE_LSB 0
`define STC_CTRL2_WAVE_MSB 2
`define STC_CTRL2_OE_LSB  4
`define STC_CTRL5_DOWN    0
`define STC_CTRL5_LOCK    1
`define STC_CTRL6_CYCV    0
`define STC_CTRL6_MV_LSB  1
`define STC_EV_A_ENABLE   0
`define STC_FLAG_PEAK     0
`define STC_FLAG_ZERO     1
`define STC_FLAG_M_LSB    4

// ----------------------------------------
// modes and reset values
// ----------------------------------------
`define STC_WAVE_NORMAL   3'h0
`define STC_WAVE_FREQ     3'h1
`define STC_WAVE_SINGLE   3'h3
`define STC_WAVE_DUAL_TOP 3'h5
`define STC_RST_CYCLE     16'hFFFF
`define STC_RST_ZERO16    16'h0000

`endif

// ===== verilog/stc_prescaler.v
`timescale 1ns/1ps
module stc_prescaler (
    input wire clk_sys,     // peripheral clock
    input wire rst_n,       // async reset, active low
    input wire run,         // counter enabled
    input wire [2:0] sel,   // prescale select
    output reg tick         // one-cycle prescaled pulse
);
    reg [9:0] div;
    reg hit;
    // ----------------------------------------
    // divide by 1,2,4,8,16,64,256,1024
    // ----------------------------------------
    always @* begin
        case (sel)
            3'h0: hit = 1'b1;
            3'h1: hit = div[0];
            3'h2: hit = &div[1:0];
            3'h3: hit = &div[2:0];
            3'h4: hit = &div[3:0];
            3'h5: hit = &div[5:0];
            3'h6: hit = &div[7:0];
            default: hit = &div[9:0];
        endcase
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div <= 10'h000;
            tick <= 1'b0;
        end else begin
            div <= run ? div + 10'h001 : 10'h000;
            tick <= run & hit;
        end
    end
endmodule

// ===== verilog/stc_channel.v
`timescale 1ns/1ps
`include "stc_map.vh"
module stc_channel (
    input wire clk_sys,        // peripheral clock
    input wire rst_n,          // async reset, active low
    input wire tick,           // timer tick
    input wire [15:0] tally,   // tally value
    input wire [15:0] cmp,     // active match value
    input wire [2:0] wave,     // wave shape select
    input wire down,           // counting down
    input wire at_zero,        // tally at zero point
    input wire restart,        // force output low
    output reg match_pend,     // tally equals match value now
    output reg wave_out        // generated waveform level
);
    wire eq = (tally == cmp);
    always @* begin
        match_pend = eq;
    end
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wave_out <= 1'b0;
        end else if (restart) begin
            wave_out <= 1'b0;
        end else if (tick) begin
            // the tick that leaves the matching count applies it
            case (wave)
                `STC_WAVE_FREQ:
                    if (eq)
                        wave_out <= ~wave_out;
                `STC_WAVE_SINGLE:
                    if (eq)
                        wave_out <= 1'b0;
                    else if (at_zero)
                        wave_out <= 1'b1;
                `STC_WAVE_DUAL_TOP:
                    if (eq)
                        wave_out <= down;
                    else if (at_zero)
                        wave_out <= 1'b1;
                default:
                    wave_out <= wave_out;
            endcase
        end
    end
endmodule

// ===== verilog/stc_timer.v
`timescale 1ns/1ps
`include "stc_map.vh"
module stc_timer (
    input wire clk_sys,        // 200 MHz peripheral clock
    input wire rst_n,          // async reset, active low
    input wire psel,           // apb select
    input wire penable,        // apb access phase
    input wire pwrite,         // apb write
    input wire [11:0] paddr,   // apb byte address
    input wire [31:0] pwdata,  // apb write data
    output reg [31:0] prdata,  // apb read data
    output reg pready,         // apb ready
    output reg pslverr,        // apb error, unmapped address
    input wire event_a,        // event input a, async
    output reg [2:0] wave_out, // waveform levels
    output reg [2:0] pin_override, // pin taken by waveform
    output reg [2:0] match_irq // per channel interrupt level
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg enable;
    reg [2:0] prescale_select;
    reg [2:0] wave_shape_select;
    reg [2:0] channel_output_enable;
    reg down;
    reg lock_refresh;
    reg event_input_a_enable;
    reg [2:0] match_irq_en;
    reg [15:0] tally_value;
    reg [15:0] cycle_length;
    reg [15:0] cycle_length_staging;
    reg cycle_staging_valid;
    reg [15:0] match_value [0:2];
    reg [15:0] match_value_staging [0:2];
    reg [2:0] match_staging_valid;
    reg [2:0] match_flag;
    reg peak_flag;
    reg zero_flag;
    reg ev_s1;
    reg ev_s2;
    reg ev_s3;
    reg [31:0] next_rdata;
    reg next_err;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function hit_addr;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit_addr = (a == ofs);
        end
    endfunction

    wire access = psel & penable & ~pready;
    wire wr = access & pwrite;
    wire wr_ctrl1 = wr & hit_addr(paddr, `STC_OFS_CTRL1);
    wire wr_ctrl2 = wr & hit_addr(paddr, `STC_OFS_CTRL2);
    wire wr_ctrl5 = wr & hit_addr(paddr, `STC_OFS_CTRL5);
    wire wr_ctrl6 = wr & hit_addr(paddr, `STC_OFS_CTRL6);
    wire wr_ev = wr & hit_addr(paddr, `STC_OFS_EVENT_CONTROL_REGISTER);
    wire wr_flags = wr & hit_addr(paddr, `STC_OFS_FLAGS);
    wire wr_tally = wr & hit_addr(paddr, `STC_OFS_TALLY);
    wire wr_cycle = wr & hit_addr(paddr, `STC_OFS_CYCLE);
    wire wr_cstg = wr & hit_addr(paddr, `STC_OFS_CYCLE_STG);

    // ----------------------------------------
    // tick sources
    // ----------------------------------------
    wire psc_tick;
    stc_prescaler u_psc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(enable),
        .sel(prescale_select),
        .tick(psc_tick)
    );

    // event pin passes two flops; third flop only for the edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1 <= 1'b0;
            ev_s2 <= 1'b0;
            ev_s3 <= 1'b0;
        end else begin
            ev_s1 <= event_a;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
        end
    end
    wire ev_tick = ev_s2 & ~ev_s3;
    wire timer_tick = enable &
        (event_input_a_enable ? ev_tick : psc_tick);

    // ----------------------------------------
    // boundary detection
    // ----------------------------------------
    wire at_zero = (tally_value == `STC_RST_ZERO16);
    wire at_max = &tally_value;
    wire at_peak = (tally_value == cycle_length);
    // dual slope turns at the peak, so it transfers at zero whatever the heading
    wire dual = (wave_shape_select == `STC_WAVE_DUAL_TOP);
    wire xfer_pt = timer_tick &
        (dual ? at_zero : (down ? at_zero : at_peak));
    wire xfer = xfer_pt & ~lock_refresh;
    // a tally past the peak while up still wraps at all-ones
    wire up_wrap = at_peak | at_max;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tally_value <= `STC_RST_ZERO16;
        end else if (wr_tally) begin
            tally_value <= pwdata[15:0];
        end else if (timer_tick) begin
            if (dual) begin
                if (!down && at_peak)
                    tally_value <= tally_value - 16'h0001;
                else if (down && at_zero)
                    tally_value <= 16'h0001;
                else if (down)
                    tally_value <= tally_value - 16'h0001;
                else
                    tally_value <= tally_value + 16'h0001;
            end else if (down) begin
                tally_value <= at_zero ? cycle_length :
                    tally_value - 16'h0001;
            end else begin
                tally_value <= up_wrap ? `STC_RST_ZERO16 :
                    tally_value + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // control and staging
    // ----------------------------------------
    integer i;
    // own index per process: one driver each
    integer j;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0;
            prescale_select <= 3'h0;
            wave_shape_select <= `STC_WAVE_NORMAL;
            channel_output_enable <= 3'h0;
            down <= 1'b0;
            lock_refresh <= 1'b0;
            event_input_a_enable <= 1'b0;
            match_irq_en <= 3'h0;
            cycle_length <= `STC_RST_CYCLE;
            cycle_length_staging <= `STC_RST_CYCLE;
            cycle_staging_valid <= 1'b0;
            match_staging_valid <= 3'h0;
            for (i = 0; i < 3; i = i + 1) begin
                match_value[i] <= `STC_RST_ZERO16;
                match_value_staging[i] <= `STC_RST_ZERO16;
            end
        end else begin
            if (wr_ctrl1) begin
                enable <= pwdata[`STC_CTRL1_ENABLE];
                prescale_select <=
                    pwdata[`STC_CTRL1_PSC_MSB:`STC_CTRL1_PSC_LSB];
            end
            if (wr_ctrl2) begin
                wave_shape_select <=
                    pwdata[`STC_CTRL2_WAVE_MSB:`STC_CTRL2_WAVE_LSB];
                channel_output_enable <= pwdata[6:4];
            end
            if (wr_ctrl5) begin
                down <= pwdata[`STC_CTRL5_DOWN];
                lock_refresh <= pwdata[`STC_CTRL5_LOCK];
            end
            if (dual && timer_tick && !down && at_peak)
                down <= 1'b1;
            else if (dual && timer_tick && down && at_zero)
                down <= 1'b0;
            if (wr_ev) begin
                event_input_a_enable <= pwdata[`STC_EV_A_ENABLE];
                match_irq_en <= pwdata[6:4];
            end
            // cycle length: transfer then direct write
            if (xfer && cycle_staging_valid) begin
                cycle_length <= cycle_length_staging;
            end
            if (wr_cycle)
                cycle_length <= pwdata[15:0];
            if (wr_cstg)
                cycle_length_staging <= pwdata[15:0];
            // staging write beats the clear at the same edge
            if (wr_cstg)
                cycle_staging_valid <= 1'b1;
            else if (wr_ctrl6)
                cycle_staging_valid <= pwdata[`STC_CTRL6_CYCV];
            else if (xfer)
                cycle_staging_valid <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                if (xfer && match_staging_valid[i])
                    match_value[i] <= match_value_staging[i];
                if (wr && paddr == `STC_OFS_MATCH0 + 4 * i)
                    match_value[i] <= pwdata[15:0];
                if (wr && paddr == `STC_OFS_STG0 + 4 * i) begin
                    match_value_staging[i] <= pwdata[15:0];
                    match_staging_valid[i] <= 1'b1;
                end else if (wr_ctrl6) begin
                    match_staging_valid[i] <=
                        pwdata[`STC_CTRL6_MV_LSB + i];
                end else if (xfer) begin
                    match_staging_valid[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // channels and flags
    // ----------------------------------------
    wire [2:0] ch_pend;
    wire [2:0] ch_wave;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_ch
            stc_channel u_ch (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .tick(timer_tick),
                .tally(tally_value),
                .cmp(match_value[g]),
                .wave(wave_shape_select),
                .down(down),
                .at_zero(at_zero),
                .restart(1'b0),
                .match_pend(ch_pend[g]),
                .wave_out(ch_wave[g])
            );
        end
    endgenerate

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            match_flag <= 3'h0;
            peak_flag <= 1'b0;
            zero_flag <= 1'b0;
            wave_out <= 3'h0;
            pin_override <= 3'h0;
            match_irq <= 3'h0;
        end else begin
            // flags rise at the tick that leaves the boundary or match,
            // so software sees them with the count already one past;
            // hardware set wins over write-one-to-clear
            for (j = 0; j < 3; j = j + 1)
                match_flag[j] <= (timer_tick & ch_pend[j]) |
                    (match_flag[j] &
                    ~(wr_flags & pwdata[`STC_FLAG_M_LSB + j]));
            peak_flag <= (timer_tick & at_peak) |
                (peak_flag & ~(wr_flags & pwdata[`STC_FLAG_PEAK]));
            zero_flag <= (timer_tick & at_zero) |
                (zero_flag & ~(wr_flags & pwdata[`STC_FLAG_ZERO]));
            match_irq <= match_flag & match_irq_en;
            wave_out <= ch_wave;
            pin_override <= (wave_shape_select != `STC_WAVE_NORMAL) ?
                channel_output_enable : 3'h0;
        end
    end

    // ----------------------------------------
    // apb read mux and answer
    // ----------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            `STC_OFS_CTRL1: next_rdata = {28'h000_0000,
                prescale_select, enable};
            `STC_OFS_CTRL2: next_rdata = {25'h000_0000,
                channel_output_enable, 1'b0, wave_shape_select};
            `STC_OFS_CTRL5: next_rdata = {30'h0000_0000,
                lock_refresh, down};
            `STC_OFS_CTRL6: next_rdata = {28'h000_0000,
                match_staging_valid, cycle_staging_valid};
            `STC_OFS_EVENT_CONTROL_REGISTER: next_rdata = {25'h000_0000,
                match_irq_en, 3'h0, event_input_a_enable};
            `STC_OFS_FLAGS: next_rdata = {25'h000_0000,
                match_flag, 2'h0, zero_flag, peak_flag};
            `STC_OFS_TALLY: next_rdata = {16'h0000, tally_value};
            `STC_OFS_CYCLE: next_rdata = {16'h0000, cycle_length};
            `STC_OFS_CYCLE_STG: next_rdata = {16'h0000,
                cycle_length_staging};
            12'h030: next_rdata = {16'h0000, match_value[0]};
            12'h034: next_rdata = {16'h0000, match_value[1]};
            12'h038: next_rdata = {16'h0000, match_value[2]};
            12'h040: next_rdata = {16'h0000, match_value_staging[0]};
            12'h044: next_rdata = {16'h0000, match_value_staging[1]};
            12'h048: next_rdata = {16'h0000, match_value_staging[2]};
            default: next_err = 1'b1;
        endcase
    end

    // one wait state: ready rises in the second access cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access & next_err;
            if (access && !pwrite)
                prdata <= next_rdata;
        end
    end
endmodule

// ===== tb/stc_timer_properties.sv
`timescale 1ns/1ps
module stc_timer_properties (
    input wire clk_sys,            // clock
    input wire rst_n,              // reset, active low
    input wire psel,               // apb select
    input wire penable,            // apb access phase
    input wire pwrite,             // apb write
    input wire [11:0] paddr,       // apb address
    input wire [31:0] pwdata,      // apb write data
    input wire [31:0] prdata,      // apb read data
    input wire pready,             // apb ready
    input wire pslverr,            // apb error
    input wire event_a,            // event line
    input wire [2:0] wave_out,     // waveform levels
    input wire [2:0] pin_override, // pin taken
    input wire [2:0] match_irq     // interrupt levels
);
    // ----------------------------------------
    // address decode and properties
    // ----------------------------------------
    wire mapped = (paddr[1:0] == 2'b00) && ((paddr <= 12'h014) ||
        (paddr >= 12'h020 && paddr <= 12'h028) ||
        (paddr >= 12'h030 && paddr <= 12'h038) ||
        (paddr >= 12'h040 && paddr <= 12'h048));
    wire wr_seen = psel && pwrite;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    ready_after_access_a: assert property (psel && penable && !pready
        |=> pready) else $error("ready late after access");
    ready_needs_access_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access phase");
    slverr_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside ready cycle");
    unmapped_err_a: assert property (pready && psel |-> pslverr == !mapped)
        else $error("error flag does not match address");
    prdata_hold_a: assert property ($changed(prdata) |->
        $past(psel && penable && !pwrite)) else $error("read data moved");
    pin_take_write_a: assert property ($changed(pin_override) |->
        ($past(wr_seen) || $past(wr_seen, 2)))
        else $error("pin takeover changed without write");
    irq_drop_write_a: assert property (
        ($past(match_irq) & ~match_irq) != 0 |->
        ($past(wr_seen) || $past(wr_seen, 2)))
        else $error("interrupt dropped without write");
endmodule

bind stc_timer stc_timer_properties stc_timer_properties_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_a(event_a),
    .wave_out(wave_out), .pin_override(pin_override),
    .match_irq(match_irq));

// ===== tb/stc_far_side.sv
`timescale 1ns/1ps
module stc_far_side #(
    parameter [2:0] PORT_OUT = 3'h2 // port's own output value
) (
    input wire clk_sys,            // clock
    input wire rst_n,              // reset, active low
    input wire [7:0] ev_count,     // events per burst
    input wire fire,               // start a burst
    input wire [2:0] wave_out,     // waveform levels
    input wire [2:0] pin_override, // pin taken by timer
    output reg event_a,            // event line
    output reg busy,               // burst running
    output wire [2:0] pin_level    // level seen on the pins
);
    reg [7:0] left;
    reg [2:0] ph;
    assign pin_level = (pin_override & wave_out) | (~pin_override & PORT_OUT);
    // four high, four low: slow enough for the two-flop synchroniser
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left <= 8'h00;
            ph <= 3'h0;
            event_a <= 1'b0;
            busy <= 1'b0;
        end else if (fire && !busy) begin
            left <= ev_count;
            busy <= (ev_count != 8'h00);
            ph <= 3'h0;
        end else if (busy) begin
            ph <= ph + 3'h1;
            event_a <= (ph < 3'h4);
            if (ph == 3'h7) begin
                left <= left - 8'h01;
                busy <= (left != 8'h01);
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "stc_map.vh"
module tb_top;
    reg clk_sys, rst_n, psel, penable, pwrite, fire;
    reg [11:0] paddr;
    reg [11:0] a;
    reg [31:0] pwdata;
    reg [7:0] ev_count;
    reg [15:0] rv;
    reg [32:0] expq[$];
    wire [31:0] prdata;
    wire pready, pslverr, event_a, busy;
    wire [2:0] wave_out, pin_override, match_irq, pin_level;
    integer failures, comparisons, seed, i;

    stc_timer stc_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_a(event_a), .wave_out(wave_out),
        .pin_override(pin_override), .match_irq(match_irq));
    stc_far_side stc_far_side_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .ev_count(ev_count), .fire(fire), .wave_out(wave_out),
        .pin_override(pin_override), .event_a(event_a), .busy(busy),
        .pin_level(pin_level));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task check(input [32:0] got, input [32:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task close_out;
        begin
            if (failures == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task apb(input wr, input [11:0] ad, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= ad;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            n = 0;
            @(posedge clk_sys);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            if (n >= 20)
                failures = failures + 1;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd(input [11:0] ad, input [31:0] e, input err);
        begin
            expq.push_back({err, e});
            apb(1'b0, ad, 32'h0000_0000);
        end
    endtask

    task events(input [7:0] k);
        integer n;
        begin
            @(posedge clk_sys);
            ev_count <= k;
            fire <= 1'b1;
            @(posedge clk_sys);
            fire <= 1'b0;
            @(posedge clk_sys);
            n = 0;
            while (busy === 1'b1 && n < 5000) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            // synchroniser and tick pipeline drain
            repeat (8) @(posedge clk_sys);
        end
    endtask

    // read results are judged where they appear
    always @(posedge clk_sys)
        if (pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0)
            check({pslverr, prdata}, expq.pop_front());

    initial begin
        #200000;
        failures = failures + 1;
        close_out;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 76;
        failures = 0;
        comparisons = 0;
        {rst_n, psel, penable, pwrite, fire} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ev_count = 8'h00;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`STC_OFS_CYCLE, 32'h0000_FFFF, 1'b0);
        rd(`STC_OFS_TALLY, 32'h0000_0000, 1'b0);
        rd(`STC_OFS_CTRL6, 32'h0000_0000, 1'b0);
        rd(12'h01C, 32'h0000_0000, 1'b1);
        apb(1'b1, 12'h02C, 32'h0000_1234);
        rv = $random(seed);
        apb(1'b1, `STC_OFS_CTRL1, {28'h0, rv[2:0], 1'b0});
        apb(1'b1, `STC_OFS_TALLY, {16'hFFFF, rv});
        repeat (50) @(posedge clk_sys);
        rd(`STC_OFS_TALLY, {16'h0000, rv}, 1'b0);
        for (i = 0; i < 3; i = i + 1) begin
            a = `STC_OFS_MATCH0 + 12'h004 * i[11:0];
            apb(1'b1, a, {16'h0000, rv + i[15:0]});
            rd(a, {16'h0000, rv + i[15:0]}, 1'b0);
        end
        apb(1'b1, `STC_OFS_CYCLE, 32'h0000_0005);
        rd(`STC_OFS_CYCLE, 32'h0000_0005, 1'b0);
        apb(1'b1, `STC_OFS_TALLY, 32'h0000_0004);
        apb(1'b1, `STC_OFS_EVENT_CONTROL_REGISTER, 32'h0000_0001);
        apb(1'b1, `STC_OFS_CTRL1, 32'h0000_0001);
        events(8'h03);
        rd(`STC_OFS_TALLY, 32'h0000_0001, 1'b0);
        apb(1'b1, `STC_OFS_CTRL5, 32'h0000_0001);
        apb(1'b1, `STC_OFS_TALLY, 32'h0000_0001);
        events(8'h03);
        rd(`STC_OFS_TALLY, 32'h0000_0004, 1'b0);
        apb(1'b1, `STC_OFS_CTRL5, 32'h0000_0002);
        apb(1'b1, `STC_OFS_TALLY, 32'h0000_0000);
        apb(1'b1, `STC_OFS_CYCLE_STG, 32'h0000_0003);
        for (i = 0; i < 3; i = i + 1)
            apb(1'b1, `STC_OFS_STG0 + 12'h004 * i[11:0], 32'h0000_0002);
        rd(`STC_OFS_CTRL6, 32'h0000_000F, 1'b0);
        events(8'h06);
        rd(`STC_OFS_CTRL6, 32'h0000_000F, 1'b0);
        rd(`STC_OFS_CYCLE, 32'h0000_0005, 1'b0);
        apb(1'b1, `STC_OFS_CTRL5, 32'h0000_0000);
        events(8'h06);
        rd(`STC_OFS_CTRL6, 32'h0000_0000, 1'b0);
        rd(`STC_OFS_CYCLE, 32'h0000_0003, 1'b0);
        rd(`STC_OFS_MATCH0 + 12'h008, 32'h0000_0002, 1'b0);
        apb(1'b1, `STC_OFS_EVENT_CONTROL_REGISTER, 32'h0000_0011);
        apb(1'b1, `STC_OFS_TALLY, 32'h0000_0001);
        apb(1'b1, `STC_OFS_FLAGS, 32'h0000_0073);
        events(8'h02);
        rd(`STC_OFS_FLAGS, 32'h0000_0070, 1'b0);
        check({30'h0000_0000, match_irq}, 33'h0_0000_0001);
        apb(1'b1, `STC_OFS_FLAGS, 32'h0000_0010);
        @(posedge clk_sys);
        check({30'h0000_0000, match_irq}, 33'h0_0000_0000);
        for (i = 0; i < 4; i = i + 1) begin
            rv = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0001 :
                 (i == 2) ? 16'h0003 : 16'h0005;
            apb(1'b1, `STC_OFS_CTRL2, {25'h0, 3'b101, 1'b0, rv[2:0]});
            @(posedge clk_sys);
            check({30'h0, pin_override}, (i == 0) ? 33'h0 : 33'h5);
        end
        // dual slope from the peak: match while down sets the outputs
        events(8'h02);
        check({30'h0000_0000, wave_out}, 33'h0_0000_0007);
        check({30'h0000_0000, pin_level}, 33'h0_0000_0007);
        apb(1'b1, `STC_OFS_CTRL2, 32'h0000_0000);
        apb(1'b1, `STC_OFS_CTRL5, 32'h0000_0000);
        apb(1'b1, `STC_OFS_EVENT_CONTROL_REGISTER, 32'h0000_0000);
        apb(1'b1, `STC_OFS_CTRL1, 32'h0000_0000);
        apb(1'b1, `STC_OFS_TALLY, 32'h0000_0000);
        // divide by 1024: first step near 1025 cycles, second near 2049
        apb(1'b1, `STC_OFS_CTRL1, 32'h0000_000F);
        repeat (1500) @(posedge clk_sys);
        rd(`STC_OFS_TALLY, 32'h0000_0001, 1'b0);
        close_out;
    end
endmodule
